/* File: core/stg_pkg.sv */
// Shared constants and types for the system clock and timing generator
package stg_pkg;
  // System clock rate and the floppy request leading-edge delay
  localparam int unsigned SYS_CLK_KHZ    = 20000;
  localparam int unsigned FDRQ_DELAY_NS  = 1000;
  localparam int unsigned FDRQ_DELAY_CYC = (FDRQ_DELAY_NS * SYS_CLK_KHZ) / 1000000;
  localparam logic [4:0]  FDRQ_CNT_LAST  = 5'(FDRQ_DELAY_CYC - 1);

  // Divider phase limits on the high-frequency oscillator
  localparam logic [1:0] DIV4_LAST  = 2'h3;  // 4 edges per fast processor clock
  localparam logic [2:0] DIV6_LAST  = 3'h5;  // 6 edges per slow processor clock
  localparam logic [2:0] DIV6_HIGH  = 3'h2;  // Slow clock is high for 2 of 6 edges
  localparam logic [1:0] DIV4_HIGH  = 2'h2;  // Fast clock is high for 2 of 4 edges

  // Processor reset ends at the third processor clock fall after release
  localparam logic [1:0] RST_FALL_LAST = 2'h2;

  // Processor status codes, as seen on the active-low status lines
  localparam logic [2:0] ST_INTA  = 3'h0;
  localparam logic [2:0] ST_IORD  = 3'h1;
  localparam logic [2:0] ST_IOWR  = 3'h2;
  localparam logic [2:0] ST_HALT  = 3'h3;
  localparam logic [2:0] ST_CODE  = 3'h4;
  localparam logic [2:0] ST_MRD   = 3'h5;
  localparam logic [2:0] ST_MWR   = 3'h6;
  localparam logic [2:0] ST_PASS  = 3'h7;

  // Asynchronous input vector layout
  localparam int unsigned SY_W     = 10;
  localparam int unsigned SY_OSCH  = 0;
  localparam int unsigned SY_OSC16 = 1;
  localparam int unsigned SY_FRQ   = 2;
  localparam int unsigned SY_RDY   = 3;
  localparam int unsigned SY_VWT   = 4;
  localparam int unsigned SY_RGIN  = 5;
  localparam int unsigned SY_HOLD  = 6;
  localparam int unsigned SY_RSTN  = 7;
  localparam int unsigned SY_FAST  = 8;
  localparam int unsigned SY_SPARE = 9;

  // System bus strobes travel together
  typedef struct packed {
    logic mem_read_n;
    logic mem_write_n;
    logic io_read_n;
    logic io_write_n;
    logic addr_latch_en;
    logic data_buffer_enable_n;
  } stg_strobe_s;

  localparam stg_strobe_s STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  // Request/grant translator states
  typedef enum logic [2:0] {RG_IDLE, RG_REQ, RG_WAIT, RG_HELD, RG_REL} stg_rg_e;
endpackage

/* File: core/stg_core.sv */
// System clock and timing generator: dividers, strobes, ready, hold and floppy selects
`timescale 1ns/100ps
// Behaviour
// - Seven clocks from two unrelated oscillators
// - Eight megahertz clock is sixteen divided two
// - Fourteen megahertz clock is high divided two
// - Colour-burst clock is high divided eight
// - Quarter clock is slow rate divided four
// - Floppy request leading edge delayed one microsecond
// - Status lines decode into bus strobes
// - Hold pair translated to request/grant pulses
// - Two floppy chip selects from address
// - Speed high: divide by four, symmetric
// - Speed low: divide by six, one-third high
module stg_core
  import stg_pkg::*;
(
  input  wire logic        clk,                         // 20 MHz system clock
  input  wire logic        srst,                        // Synchronous reset, active high
  input  wire logic        osc_high_in,                 // High-frequency oscillator
  input  wire logic        osc_sixteen_in,              // Sixteen megahertz oscillator
  input  wire logic        speed_fast,                  // Speed select, high = fast
  input  wire logic        sys_reset_n,                 // System reset pin, active low
  input  wire logic [2:0]  cpu_status_n,                // {status2, status1, status0}, active low
  input  wire logic        ready_async_in,              // Asynchronous ready, low = wait
  input  wire logic        video_wait_n,                // Video wait, low = wait
  input  wire logic        floppy_dma_request,          // Floppy DMA request
  input  wire logic        floppy_func_select_n,        // Pre-decoded floppy function select
  input  wire logic        addr_bit2,                   // System address bit 2
  input  wire logic        system_hold_request_n,       // Hold request, active low
  input  wire logic        cpu_request_grant_n_in,      // Request/grant pin level
  output logic             cpu_request_grant_n_out,     // Request/grant drive value
  output logic             cpu_request_grant_n_oe,      // Request/grant drive enable
  output logic             system_hold_ack,             // Hold acknowledge
  output logic             clk_eight_out,               // Sixteen divided by two
  output logic             clk_four_out,                // Sixteen divided by four
  output logic             clk_fourteen_out,            // High divided by two
  output logic             clk_colorburst_out,          // High divided by eight
  output logic             clk_slow_cpu_rate_out,       // High divided by six
  output logic             clk_quarter_slow_out,        // Slow rate divided by four
  output logic             processor_clock,             // Selected processor clock
  output logic             cpu_ready,                   // Processor ready
  output logic             cpu_reset,                   // Processor reset, active high
  output logic             floppy_dma_request_delayed,  // Delayed floppy request
  output logic             floppy_select_n,             // Floppy select, address bit 2 low
  output logic             floppy_chip_select_n,        // Floppy chip select, address bit 2 high
  output stg_strobe_s      bus_strobe                   // Bus strobes, latch and buffer enable
);

  // Two-flop synchronisers; a third stage is read only for the oscillator edges
  logic [SY_W-1:0] sy1_r, sy2_r, sy3_r;
  wire  [SY_W-1:0] sy_in = {1'b0, speed_fast, sys_reset_n, system_hold_request_n,
                            cpu_request_grant_n_in, video_wait_n, ready_async_in,
                            floppy_dma_request, osc_sixteen_in, osc_high_in};
  always_ff @(posedge clk) begin
    sy1_r <= sy_in;
    sy2_r <= sy1_r;
    sy3_r <= sy2_r;
  end

  // Oscillator edges; both oscillators must stay below half the system clock
  wire osch_rise = sy2_r[SY_OSCH] & ~sy3_r[SY_OSCH];
  wire osc16_rise = sy2_r[SY_OSC16] & ~sy3_r[SY_OSC16];

  // Divider counters on the high oscillator
  logic [1:0] c4_r, c4_nxt;
  logic [2:0] c6_r, c6_nxt;
  logic       q_r, e4_r;
  assign c4_nxt = osch_rise ? c4_r + 2'h1 : c4_r;
  assign c6_nxt = osch_rise ? ((c6_r == DIV6_LAST) ? 3'h0 : c6_r + 3'h1) : c6_r;
  wire   slow_nxt = c6_nxt < DIV6_HIGH;
  wire   fast_nxt = c4_nxt < DIV4_HIGH;
  // Speed select is steered by the system, sampled through the synchroniser
  wire   cpu_nxt  = sy2_r[SY_FAST] ? fast_nxt : slow_nxt;
  wire   cpu_rise = cpu_nxt & ~processor_clock;
  wire   cpu_fall = ~cpu_nxt & processor_clock;
  wire   slow_wrap = osch_rise & (c6_r == DIV6_LAST);

  // Clock outputs, each a register toggled or decoded from the counters
  always_ff @(posedge clk) begin
    if (srst) begin
      c4_r <= 2'h0;
      c6_r <= 3'h0;
      q_r  <= 1'b0;
      e4_r <= 1'b0;
      clk_fourteen_out      <= 1'b0;
      clk_colorburst_out    <= 1'b0;
      clk_slow_cpu_rate_out <= 1'b0;
      clk_quarter_slow_out  <= 1'b0;
      clk_eight_out         <= 1'b0;
      clk_four_out          <= 1'b0;
      processor_clock       <= 1'b0;
    end else begin
      c4_r <= c4_nxt;
      c6_r <= c6_nxt;
      processor_clock       <= cpu_nxt;
      clk_slow_cpu_rate_out <= slow_nxt;
      if (osch_rise) clk_fourteen_out <= ~clk_fourteen_out;
      if (osch_rise && c4_r == DIV4_LAST) clk_colorburst_out <= ~clk_colorburst_out;
      // Two slow periods per half cycle gives divide by four
      if (slow_wrap) q_r <= ~q_r;
      if (slow_wrap && q_r) clk_quarter_slow_out <= ~clk_quarter_slow_out;
      if (osc16_rise) clk_eight_out <= ~clk_eight_out;
      if (osc16_rise) e4_r <= ~e4_r;
      if (osc16_rise && e4_r) clk_four_out <= ~clk_four_out;
    end
  end

  // Floppy request: rising edge waits the delay, falling edge passes at once
  logic [4:0] fd_cnt_r;
  wire fd_req = sy2_r[SY_FRQ];
  always_ff @(posedge clk) begin
    if (srst || !fd_req) begin
      fd_cnt_r <= 5'h0;
      floppy_dma_request_delayed <= 1'b0;
    end else if (fd_cnt_r == FDRQ_CNT_LAST) begin
      floppy_dma_request_delayed <= 1'b1;
    end else begin
      fd_cnt_r <= fd_cnt_r + 5'h1;
    end
  end

  // Floppy chip selects; function select comes from logic on this board's bus decode
  always_ff @(posedge clk) begin
    if (srst) begin
      floppy_select_n      <= 1'b1;
      floppy_chip_select_n <= 1'b1;
    end else begin
      floppy_select_n      <= floppy_func_select_n | addr_bit2;
      floppy_chip_select_n <= floppy_func_select_n | ~addr_bit2;
    end
  end

  // Status decode, sampled at processor clock rising edges
  wire st_mr = cpu_status_n == ST_MRD || cpu_status_n == ST_CODE;
  wire st_mw = cpu_status_n == ST_MWR;
  wire st_ir = cpu_status_n == ST_IORD;
  wire st_iw = cpu_status_n == ST_IOWR;
  wire st_bus = st_mr | st_mw | st_ir | st_iw | (cpu_status_n == ST_INTA);
  logic prev_pass_r;
  always_ff @(posedge clk) begin
    if (srst || sy2_r[SY_HOLD] == 1'b0 && system_hold_ack) begin
      bus_strobe  <= STROBE_IDLE;
      prev_pass_r <= 1'b1;
    end else if (cpu_rise) begin
      // Latch pulses for one processor clock when a cycle starts
      bus_strobe.addr_latch_en        <= prev_pass_r & st_bus;
      bus_strobe.mem_read_n           <= ~st_mr;
      bus_strobe.mem_write_n          <= ~st_mw;
      bus_strobe.io_read_n            <= ~st_ir;
      bus_strobe.io_write_n           <= ~st_iw;
      bus_strobe.data_buffer_enable_n <= ~st_bus;
      prev_pass_r <= cpu_status_n == ST_PASS;
    end
  end

  // Ready: both wait sources combined, moved only on processor clock falls
  wire rdy_all = sy2_r[SY_RDY] & sy2_r[SY_VWT];
  always_ff @(posedge clk) begin
    if (srst) cpu_ready <= 1'b0;
    else if (cpu_fall) cpu_ready <= rdy_all;
  end

  // Processor reset stays on until the third processor clock fall after release
  logic [1:0] rst_cnt_r;
  always_ff @(posedge clk) begin
    if (srst || !sy2_r[SY_RSTN]) begin
      rst_cnt_r <= 2'h0;
      cpu_reset <= 1'b1;
    end else if (cpu_fall) begin
      if (rst_cnt_r == RST_FALL_LAST) cpu_reset <= 1'b0;
      else rst_cnt_r <= rst_cnt_r + 2'h1;
    end
  end

  // Request/grant translator; each pulse lasts one processor clock
  stg_rg_e rg_r;
  logic [1:0] rg_echo_r;
  wire hold_req = ~sy2_r[SY_HOLD];
  wire grant_seen = ~sy2_r[SY_RGIN];
  // Our own request pulse returns through the synchroniser two clocks late;
  // without this mask it would be taken for the processor's grant
  wire grant_valid = grant_seen & ~cpu_request_grant_n_oe & ~|rg_echo_r;
  always_ff @(posedge clk) begin
    if (srst) rg_echo_r <= 2'h0;
    else rg_echo_r <= {rg_echo_r[0], cpu_request_grant_n_oe};
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rg_r <= RG_IDLE;
      cpu_request_grant_n_out <= 1'b1;
      cpu_request_grant_n_oe  <= 1'b0;
      system_hold_ack         <= 1'b0;
    end else begin
      case (rg_r)
        RG_IDLE: if (hold_req && cpu_rise) begin
          rg_r <= RG_REQ;
          cpu_request_grant_n_out <= 1'b0;
          cpu_request_grant_n_oe  <= 1'b1;
        end
        RG_REQ: if (cpu_rise) begin
          rg_r <= RG_WAIT;
          cpu_request_grant_n_out <= 1'b1;
          cpu_request_grant_n_oe  <= 1'b0;
        end
        // Grant pulse from the processor hands over the bus
        RG_WAIT: if (grant_valid) begin
          rg_r <= RG_HELD;
          system_hold_ack <= 1'b1;
        end
        RG_HELD: if (!hold_req && !grant_seen && cpu_rise) begin
          rg_r <= RG_REL;
          system_hold_ack <= 1'b0;
          cpu_request_grant_n_out <= 1'b0;
          cpu_request_grant_n_oe  <= 1'b1;
        end
        RG_REL: if (cpu_rise) begin
          rg_r <= RG_IDLE;
          cpu_request_grant_n_out <= 1'b1;
          cpu_request_grant_n_oe  <= 1'b0;
        end
        default: rg_r <= RG_IDLE;
      endcase
    end
  end

endmodule

/* File: tb/stg_properties.sv */
// Concurrent checks on the timing generator outputs
`timescale 1ns/100ps
module stg_checker
  import stg_pkg::*;
(
  input wire logic        clk,                         // Clock
  input wire logic        srst,                        // Reset
  input wire stg_strobe_s bus_strobe,                  // Strobes
  input wire logic        cpu_reset,                   // Processor reset
  input wire logic        floppy_func_select_n,        // Function select
  input wire logic        addr_bit2,                   // Address bit 2
  input wire logic        floppy_select_n,             // Select
  input wire logic        floppy_chip_select_n,        // Chip select
  input wire logic        clk_fourteen_out,            // High div 2
  input wire logic        clk_colorburst_out,          // High div 8
  input wire logic        floppy_dma_request,          // Request
  input wire logic        floppy_dma_request_delayed,  // Delayed request
  input wire logic        cpu_ready,                   // Processor ready
  input wire logic        processor_clock,             // Processor clock level
  input wire logic        cpu_request_grant_n_oe,      // Pin enable
  input wire logic        cpu_request_grant_n_out      // Pin value
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Relations between outputs and their causes
  property p_rst; $fell(srst) |-> bus_strobe == STROBE_IDLE && cpu_reset; endproperty
  property p_sel; !floppy_func_select_n && !addr_bit2 |=> !floppy_select_n && floppy_chip_select_n; endproperty
  property p_csel; !floppy_func_select_n && addr_bit2 |=> floppy_select_n && !floppy_chip_select_n; endproperty
  property p_nsel; floppy_func_select_n |=> floppy_select_n && floppy_chip_select_n; endproperty
  property p_cb; $changed(clk_colorburst_out) |-> $changed(clk_fourteen_out); endproperty
  // Only the leading edge waits the full delay; the trailing edge follows quickly
  property p_fdr; $rose(floppy_dma_request_delayed) |-> $past(floppy_dma_request, 20); endproperty
  property p_fdf; !floppy_dma_request [*4] |-> !floppy_dma_request_delayed; endproperty
  property p_rg; $rose(cpu_request_grant_n_oe) |-> (cpu_request_grant_n_oe && !cpu_request_grant_n_out) [*8]; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_sel: assert property (p_sel) else $error("select wrong");
  a_csel: assert property (p_csel) else $error("chip select wrong");
  a_nsel: assert property (p_nsel) else $error("idle select wrong");
  a_cb: assert property (p_cb) else $error("burst clock off edge");
  a_fdr: assert property (p_fdr) else $error("delayed request early");
  a_fdf: assert property (p_fdf) else $error("delayed request stuck");
  a_rg: assert property (p_rg) else $error("request pulse short");
  // Ready moves, and processor reset is released, only where the processor clock falls
  property p_rdy; $changed(cpu_ready) |-> $fell(processor_clock); endproperty
  property p_rrel; $fell(cpu_reset) |-> $fell(processor_clock); endproperty
  a_rdy: assert property (p_rdy) else $error("ready moved off clock fall");
  a_rrel: assert property (p_rrel) else $error("processor reset released off clock fall");
  c_rg: cover property ($rose(cpu_request_grant_n_oe));
  c_fd: cover property ($rose(floppy_dma_request_delayed));
  c_cs: cover property (!floppy_chip_select_n);
endmodule
bind stg_core stg_checker i_chk (.*);

/* File: tb/stg_cpu_model.sv */
// Processor-side model: status lines and the shared request/grant pin
`timescale 1ns/100ps
module stg_cpu_model
  import stg_pkg::*;
(
  input  wire logic  processor_clock,          // Processor clock
  input  wire logic  cpu_request_grant_n_out,  // Block pin value
  input  wire logic  cpu_request_grant_n_oe,   // Block pin enable
  output logic [2:0] cpu_status_n,             // Status lines
  output logic       cpu_request_grant_n_in    // Resolved pin
);
  logic grant_n = 1'h1;
  logic held    = 1'h0;
  // Pulled-up pin: a low from either side wins
  assign cpu_request_grant_n_in = (cpu_request_grant_n_oe ? cpu_request_grant_n_out : 1'h1) & grant_n;
  initial cpu_status_n = ST_PASS;
  // Status changes just after a processor clock rise
  task automatic drive(input logic [2:0] code);
    @(posedge processor_clock);
    #5 cpu_status_n = code;
  endtask
  // Grant two periods after a request; the next pulse is a release
  always @(posedge cpu_request_grant_n_oe) begin
    if (held) begin
      held = 1'h0;
    end else begin
      @(negedge cpu_request_grant_n_oe);
      repeat (2) @(posedge processor_clock);
      #5 grant_n = 1'h0;
      @(posedge processor_clock);
      #5 grant_n = 1'h1;
      held = 1'h1;
    end
  end
endmodule

/* File: tb/system_clock_timing_generator_bench.sv */
// Self-checking bench for the system clock and timing generator
`timescale 1ns/100ps
module system_clock_timing_generator_bench
  import stg_pkg::*;
();
  logic        clk = 1'h0, srst = 1'h1, osc_high_in = 1'h0, osc_sixteen_in = 1'h0, speed_fast = 1'h0;
  logic        sys_reset_n = 1'h0, ready_async_in = 1'h1, video_wait_n = 1'h1, floppy_dma_request = 1'h0;
  logic        floppy_func_select_n = 1'h1, addr_bit2 = 1'h0, system_hold_request_n = 1'h1;
  logic        cpu_request_grant_n_in, cpu_request_grant_n_out, cpu_request_grant_n_oe, system_hold_ack;
  logic        clk_eight_out, clk_four_out, clk_fourteen_out, clk_colorburst_out, clk_slow_cpu_rate_out;
  logic        clk_quarter_slow_out, processor_clock, cpu_ready, cpu_reset, floppy_dma_request_delayed;
  logic        floppy_select_n, floppy_chip_select_n;
  logic [2:0]  cpu_status_n;
  logic [8:0]  sig_v, sig_q;
  logic [3:0]  mon;
  stg_strobe_s bus_strobe;
  int          n_errors = 0, samples_checked = 0, waited, hi, r [9];
  stg_core i_dut (.*);
  stg_cpu_model i_cpu (.*);
  // Clock and two oscillators; each oscillator level spans two or three clk edges
  always #25 clk = ~clk;
  always #100 osc_high_in = ~osc_high_in;
  always #150 osc_sixteen_in = ~osc_sixteen_in;
  assign sig_v = {processor_clock, clk_quarter_slow_out, clk_slow_cpu_rate_out, clk_colorburst_out,
                  clk_fourteen_out, clk_four_out, clk_eight_out, osc_sixteen_in, osc_high_in};
  assign mon = {cpu_reset, floppy_dma_request_delayed, cpu_ready, system_hold_ack};
  // Rising edges and processor clock high time, counted all the time and cleared per window
  always @(posedge clk) begin
    sig_q <= sig_v;
    for (int i = 0; i < 9; i++) r[i] += sig_v[i] & !sig_q[i];
    hi += processor_clock;
  end
  task automatic check_eq(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_near(input int got, input int exp, input int tol);
    samples_checked++;
    if (got > exp + tol || got < exp - tol) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // Bounded wait for a watched output, then judge its level
  task automatic await(input int idx, input logic v);
    waited = 0;
    while (mon[idx] !== v && waited < 400) begin
      @(posedge clk);
      waited++;
    end
    #5 check_eq({5'h0, mon[idx]}, {5'h0, v});
  endtask
  task automatic test_reset();
    step(4);
    check_eq({5'h0, cpu_reset}, 6'h1);
    sys_reset_n = 1'h1;
    await(3, 1'h0);
    check_near(waited, 60, 36);
    $display("reset test done");
  endtask
  // Counting window of 2400 clk; the speed input is the system's choice
  task automatic measure(input logic fast);
    speed_fast = fast;
    step(60);
    r = '{default: 0};
    hi = 0;
    step(2400);
  endtask
  task automatic test_clocks();
    measure(1'h1);
    check_near(r[0], 600, 1);
    check_near(r[2], r[1] / 2, 1);
    check_near(r[3], r[1] / 4, 1);
    check_near(r[4], r[0] / 2, 1);
    check_near(r[5], r[0] / 8, 1);
    check_near(r[7], r[6] / 4, 1);
    check_near(r[6], r[0] / 6, 1);
    check_near(r[8], r[0] / 4, 1);
    check_near(hi, 1200, 24);
    measure(1'h0);
    check_near(r[8], r[0] / 6, 1);
    check_near(hi, 800, 24);
    $display("clock test done");
  endtask
  // A long request is delayed, a short one never shows
  task automatic test_floppy();
    floppy_dma_request = 1'h1;
    await(2, 1'h1);
    check_near(waited, FDRQ_DELAY_CYC + 2, 2);
    floppy_dma_request = 1'h0;
    step(5);
    check_eq({5'h0, floppy_dma_request_delayed}, 6'h0);
    floppy_dma_request = 1'h1;
    step(FDRQ_DELAY_CYC / 2);
    floppy_dma_request = 1'h0;
    step(40);
    check_eq({5'h0, floppy_dma_request_delayed}, 6'h0);
    $display("floppy test done");
  endtask
  task automatic test_strobes();
    logic [5:0] exp_t [8] = '{6'h3e, 6'h36, 6'h3a, 6'h3d, 6'h1e, 6'h1e, 6'h2e, 6'h3d};
    for (int c = 0; c < 8; c++) begin
      i_cpu.drive(3'(c));
      @(posedge processor_clock);
      #100 check_eq(bus_strobe, exp_t[c]);
      i_cpu.drive(ST_PASS);
      @(posedge processor_clock);
    end
    $display("strobe test done");
  endtask
  // A memory cycle in progress is silenced once the grant arrives
  task automatic test_hold();
    system_hold_request_n = 1'h0;
    i_cpu.drive(ST_MRD);
    await(0, 1'h1);
    check_eq({5'h0, i_cpu.grant_n}, 6'h0);
    check_eq(bus_strobe, STROBE_IDLE);
    i_cpu.drive(ST_PASS);
    system_hold_request_n = 1'h1;
    await(0, 1'h0);
    step(40);
    check_eq({5'h0, i_cpu.held}, 6'h0);
    $display("hold test done");
  endtask
  // Either wait source stalls the processor, then ready returns
  task automatic test_ready();
    for (int k = 0; k < 2; k++) begin
      {ready_async_in, video_wait_n} = k ? 2'h1 : 2'h2;
      await(1, 1'h0);
      {ready_async_in, video_wait_n} = 2'h3;
      await(1, 1'h1);
    end
    for (int k = 0; k < 4; k++) begin
      {floppy_func_select_n, addr_bit2} = 2'(k);
      step(2);
      check_eq({4'h0, floppy_select_n, floppy_chip_select_n}, {4'h0, k[1] | k[0], k[1] | !k[0]});
    end
    $display("ready and select test done");
  endtask
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    step(20);
    srst = 1'h0;
    test_reset();
    test_clocks();
    test_floppy();
    test_strobes();
    test_hold();
    test_ready();
    conclude();
  end
  // Tests need about 6000 clk; 40000 clk means a hang
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end
endmodule
